/* bench/lcs_contactor_model.sv */
// Line contactor model: coil in, auxiliary contact out after a mechanical delay.
`timescale 1ns/100ps
module lcs_contactor_model (
  input wire core_clk_i,
  input wire coil_i,
  input wire stuck_i,
  input wire nc_i,
  output wire fb_o
);
  logic [2:0] pos_q = 3'h0;
  // A stuck contact never closes, so the far side can miss its feedback on purpose.
  always @(posedge core_clk_i) pos_q <= {pos_q[1:0], coil_i & ~stuck_i};
  assign fb_o = pos_q[2] ^ nc_i;
endmodule // lcs_contactor_model

/* bench/lcs_line_contactor_sequencer_asserts.sv */
// Port-level assertions for the line contactor sequencer.
`timescale 1ns/100ps
module lcs_line_contactor_sequencer_asserts #(
  parameter [31:0] MON_CYC_DEF = 50,
  parameter [31:0] HOLD_CYC_DEF = 20
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire drive_on_i,
  input wire fault_ack_i,
  input wire [7:0] digital_output_o,
  input wire contactor_activate_signal_o,
  input wire contactor_feedback_fault_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire acc = psel_i && penable_i;
  a_ready_always_high: assert property (pready_o) else $error("pready low");
  a_unmapped_err: assert property (acc && paddr_i > 12'h018 |-> pslverr_o) else $error("no slave error");
  a_mapped_no_err: assert property (acc && paddr_i <= 12'h018 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("slave error on mapped");
  a_idle_no_err: assert property (!acc |-> !pslverr_o && prdata_o == 32'h0) else $error("bus out of phase");
  a_output_follows_act: assert property ((digital_output_o & ~{8{$past(contactor_activate_signal_o)}}) == 8'h0)
    else $error("output without activation");
  a_act_rise_cause: assert property ($rose(contactor_activate_signal_o) |-> $past(drive_on_i, 2) ||
    $past(drive_on_i, 3) || $past(drive_on_i, 4) || $past(acc && pwrite_i)) else $error("activation without cause");
  a_fault_stays_latched: assert property ($fell(contactor_feedback_fault_o) |-> $past(fault_ack_i, 2) ||
    $past(fault_ack_i, 3) || $past(fault_ack_i, 4)) else $error("fault cleared without ack");
  a_read_stable_err: assert property (acc && pslverr_o && !pwrite_i |-> prdata_o == 32'h0) else $error("unmapped data");
endmodule // lcs_line_contactor_sequencer_asserts
bind lcs_line_contactor_sequencer lcs_line_contactor_sequencer_asserts #(.MON_CYC_DEF(MON_CYC_DEF),
  .HOLD_CYC_DEF(HOLD_CYC_DEF)) chk_inst (.core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .prdata_o, .pready_o, .pslverr_o, .drive_on_i, .fault_ack_i, .digital_output_o, .contactor_activate_signal_o,
  .contactor_feedback_fault_o);

/* bench/lcs_line_contactor_sequencer_tb_top.sv */
// Self-checking testbench for the line contactor sequencer.
`timescale 1ns/100ps
module lcs_line_contactor_sequencer_tb_top;
  logic core_clk_i = 0, nrst_i = 0, psel = 0, pen = 0, pwr = 0, drv = 0, sto = 0, ack = 0, stuck = 0, nc = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [7:0] digital_input_x = 0;
  wire [31:0] prdata;
  wire [7:0] dout;
  wire pready, pslverr, act, fault, irq, fb;
  logic [31:0] q[$];
  int fail_count = 0, n_tests = 0, cnt, di;
  initial forever #4 core_clk_i = ~core_clk_i;
  lcs_line_contactor_sequencer #(.MON_CYC_DEF(50), .HOLD_CYC_DEF(20)) lcs_line_contactor_sequencer_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .drive_on_i(drv),
    .sto_active_i(sto), .fault_ack_i(ack), .digital_input_x_i(digital_input_x), .digital_output_o(dout),
    .contactor_activate_signal_o(act), .contactor_feedback_fault_o(fault), .irq_o(irq));
  lcs_contactor_model lcs_contactor_model_inst (.core_clk_i(core_clk_i), .coil_i(dout[2]), .stuck_i(stuck),
    .nc_i(nc), .fb_o(fb));
  // Unused inputs carry random noise so only the selected one can matter.
  always @(posedge core_clk_i) digital_input_x <= ($urandom & ~(8'h01 << di)) | (8'(fb) << di);
  task chk(input [31:0] g, input [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task results;
    $display("fails %0d checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_i) if (psel && pen && pready && !pwr) chk(prdata, q.pop_front());
  task apb(input bit w, input [11:0] a, input [31:0] d);
    @(posedge core_clk_i);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk_i);
    pen <= 1;
    cnt = 0;
    do @(posedge core_clk_i); while (pready !== 1'b1 && ++cnt < 50);
    if (pready !== 1'b1) begin
      chk(0, 1);
      results;
    end
    {psel, pen} <= 2'h0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    q.push_back(e);
    apb(0, a, 0);
  endtask
  task wt(input logic e);
    cnt = 0;
    while (act !== e) begin
      @(posedge core_clk_i);
      if (++cnt > 300) begin
        chk(0, 1);
        results;
      end
    end
  endtask
  initial begin
    di = $urandom(31);
    di = $urandom % 8;
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1;
    rd(12'h000, 32'h0); rd(12'h004, 32'd50); rd(12'h008, 32'd20); rd(12'h010, 32'h2); rd(12'h01C, 32'h0);
    apb(1, 12'h00C, 32'h4);
    for (int k = 0; k < 2; k++) begin
      nc <= k[0];
      apb(1, 12'h000, (di << 4) | (k + 1));
      drv <= 1;
      wt(1);
      repeat (80) @(posedge core_clk_i);
      chk({dout, fault}, {8'h04, 1'b0});
      drv <= 0;
      wt(0);
      chk(cnt >= 20 && cnt <= 25, 1);
      repeat (10) @(posedge core_clk_i);
    end
    stuck <= 1;
    apb(1, 12'h018, 32'h1);
    drv <= 1;
    wt(1);
    wt(0);
    chk({cnt >= 48 && cnt <= 56, irq}, 2'h3);
    {stuck, drv} <= 2'h0;
    repeat (20) @(posedge core_clk_i);
    chk(fault, 1);
    rd(12'h014, 32'h3);
    apb(1, 12'h014, 32'h3);
    @(posedge core_clk_i);
    chk(irq, 0);
    ack <= 1;
    repeat (6) @(posedge core_clk_i);
    chk(fault, 0);
    ack <= 0;
    for (int s = 0; s < 2; s++) begin
      apb(1, 12'h000, s << 8);
      drv <= 1;
      wt(1);
      sto <= 1;
      wt(0);
      chk(s ? cnt >= 20 : cnt <= 4, 1);
      {sto, drv} <= 2'h0;
      repeat (30) @(posedge core_clk_i);
      chk({fault, irq}, 2'h0);
    end
    apb(1, 12'h000, 32'h200);
    wt(1);
    repeat (40) @(posedge core_clk_i);
    chk(act, 1);
    apb(1, 12'h000, 32'h0);
    wt(0);
    results;
  end
endmodule // lcs_line_contactor_sequencer_tb_top

/* rtl/lcs_consts.vh */
// Constants for the line contactor sequencer: register map, field layout, reset values, timing.
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH
// ==========================================================
// Register byte addresses
`define LCS_ADDR_CTRL 12'h000
`define LCS_ADDR_MON_TIME 12'h004
`define LCS_ADDR_HOLD_TIME 12'h008
`define LCS_ADDR_OUT_SEL 12'h00C
`define LCS_ADDR_STATUS 12'h010
`define LCS_ADDR_IRQ_STAT 12'h014
`define LCS_ADDR_IRQ_MASK 12'h018
// ==========================================================
// Control register fields
`define LCS_CTRL_SRC_LSB 0
`define LCS_CTRL_SRC_MSB 1
`define LCS_CTRL_DI_LSB 4
`define LCS_CTRL_DI_MSB 6
`define LCS_CTRL_SEQ 8
`define LCS_CTRL_FORCE 9
// Feedback source encodings.
`define LCS_SRC_NONE 2'h0
`define LCS_SRC_NO 2'h1
`define LCS_SRC_NC 2'h2
// Status and interrupt bits.
`define LCS_ST_ACT 0
`define LCS_ST_FB 1
`define LCS_ST_FAULT 2
`define LCS_ST_HOLD 3
`define LCS_IRQ_FAULT 0
`define LCS_IRQ_OPEN 1
// ==========================================================
// Timing: times in ms, clock 125 MHz, counts in cycles
`define LCS_CLK_HZ 125000000
`define LCS_MON_TIME_MS 100
`define LCS_HOLD_TIME_MS 50
`define LCS_CYC_PER_MS (`LCS_CLK_HZ / 1000)
`define LCS_MON_CYC (`LCS_MON_TIME_MS * `LCS_CYC_PER_MS)
`define LCS_HOLD_CYC (`LCS_HOLD_TIME_MS * `LCS_CYC_PER_MS)
`endif

/* rtl/lcs_line_contactor_sequencer.v */
// Line contactor sequencer with APB register slave and interrupt.
`timescale 1ns/100ps
`include "lcs_consts.vh"
// What this block does
// - An internal contactor activation signal is produced and drives every digital output whose source selects it.
// - Feedback source is none (default), a normally-open contact on a chosen input, or a normally-closed one read inverted.
// - A feedback fault is raised when expected feedback stays absent past the monitoring time, default 100 ms.
// - Feedback is monitored only when a source is selected; with none the fault is never raised.
// - After a normal stop the contactor stays closed for the holding time, default 50 ms, then opens.
// - With sequence configuration 0 the contactor opens at once when Safe Torque Off becomes active.
// - With sequence configuration 1 the contactor opens under Safe Torque Off only after the holding time.
// - While force-closed is 1 the contactor stays closed through stop and fault; default 0.
module lcs_line_contactor_sequencer #(
  parameter [31:0] MON_CYC_DEF = `LCS_MON_CYC,
  parameter [31:0] HOLD_CYC_DEF = `LCS_HOLD_CYC
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire drive_on_i,
  input wire sto_active_i,
  input wire fault_ack_i,
  input wire [7:0] digital_input_x_i,
  output reg [7:0] digital_output_o,
  output wire contactor_activate_signal_o,
  output wire contactor_feedback_fault_o,
  output wire irq_o
);

  // ==========================================================
  // Input synchronisers
  reg [7:0] di_s1_q;
  reg [7:0] di_s2_q;
  reg [2:0] ctl_s1_q;
  reg [2:0] ctl_s2_q;
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      di_s1_q <= 8'h00;
      di_s2_q <= 8'h00;
      ctl_s1_q <= 3'h0;
      ctl_s2_q <= 3'h0;
    end else begin
      di_s1_q <= digital_input_x_i;
      di_s2_q <= di_s1_q;
      ctl_s1_q <= {fault_ack_i, sto_active_i, drive_on_i};
      ctl_s2_q <= ctl_s1_q;
    end
  end
  wire drive_on = ctl_s2_q[0];
  wire sto_on = ctl_s2_q[1];
  wire ack_on = ctl_s2_q[2];

  // ==========================================================
  // Registers
  reg [1:0] fb_src_q;
  reg [2:0] fb_di_q;
  reg seq_cfg_q;
  reg force_q;
  reg [31:0] mon_time_q;
  reg [31:0] hold_time_q;
  reg [7:0] out_sel_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg fault_q;
  reg [31:0] hold_cnt_q;
  reg [31:0] mon_cnt_q;
  reg cmd_prev_q;

  wire wr_en = psel_i & penable_i & pwrite_i;
  wire rd_en = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;

  function addr_known;
    input [11:0] a;
    begin
      addr_known = (a == `LCS_ADDR_CTRL) || (a == `LCS_ADDR_MON_TIME) || (a == `LCS_ADDR_HOLD_TIME) ||
                   (a == `LCS_ADDR_OUT_SEL) || (a == `LCS_ADDR_STATUS) || (a == `LCS_ADDR_IRQ_STAT) ||
                   (a == `LCS_ADDR_IRQ_MASK);
    end
  endfunction
  assign pslverr_o = psel_i & penable_i & ~addr_known(paddr_i);

  // Write hits are decoded once so every register agrees on the map.
  function wr_hit;
    input en;
    input [11:0] a;
    input [11:0] target;
    begin
      wr_hit = en && (a == target);
    end
  endfunction
  wire wr_ctrl = wr_hit(wr_en, paddr_i, `LCS_ADDR_CTRL);
  wire wr_mon = wr_hit(wr_en, paddr_i, `LCS_ADDR_MON_TIME);
  wire wr_hold = wr_hit(wr_en, paddr_i, `LCS_ADDR_HOLD_TIME);
  wire wr_osel = wr_hit(wr_en, paddr_i, `LCS_ADDR_OUT_SEL);
  wire wr_irq = wr_hit(wr_en, paddr_i, `LCS_ADDR_IRQ_STAT);
  wire wr_mask = wr_hit(wr_en, paddr_i, `LCS_ADDR_IRQ_MASK);

  // ==========================================================
  // Feedback selection
  wire fb_raw = di_s2_q[fb_di_q];
  reg fb_ok;
  always @* begin
    case (fb_src_q)
      `LCS_SRC_NO: fb_ok = fb_raw;
      `LCS_SRC_NC: fb_ok = ~fb_raw;
      default: fb_ok = 1'b1;
    endcase
  end
  wire fb_enabled = (fb_src_q == `LCS_SRC_NO) || (fb_src_q == `LCS_SRC_NC);

  // ==========================================================
  // Contactor command sequencing
  // The hold timer runs on a normal stop, and under Safe Torque Off only when configured for a delayed open.
  localparam [1:0] SEQ_OPEN = 2'h0;
  localparam [1:0] SEQ_RUN = 2'h1;
  localparam [1:0] SEQ_HOLD = 2'h2;
  reg [1:0] seq_state_q;
  reg [1:0] seq_state_d;
  reg [31:0] hold_cnt_d;
  wire act_on = (seq_state_q == SEQ_RUN);
  wire hold_on = (seq_state_q == SEQ_HOLD);
  wire hold_done = (hold_cnt_q == 32'h0000_0000);
  wire hold_allowed = ~sto_on | seq_cfg_q;
  wire fault_blocks = fault_q & ~force_q;
  wire run_req = drive_on & ~sto_on & ~fault_blocks;
  wire cmd_d = force_q | ((act_on | hold_on) & ~fault_q);
  assign contactor_activate_signal_o = cmd_d;
  assign contactor_feedback_fault_o = fault_q;

  // A fault drops the contactor at once unless forced; the hold only serves orderly stops.
  always @* begin
    seq_state_d = seq_state_q;
    hold_cnt_d = hold_cnt_q;
    case (seq_state_q)
      SEQ_OPEN: begin
        if (run_req) begin
          seq_state_d = SEQ_RUN;
          hold_cnt_d = hold_time_q;
        end
      end
      SEQ_RUN: begin
        hold_cnt_d = hold_time_q;
        if (!run_req) begin
          if (hold_allowed && !fault_blocks) begin
            seq_state_d = SEQ_HOLD;
          end else begin
            seq_state_d = SEQ_OPEN;
          end
        end
      end
      SEQ_HOLD: begin
        if (run_req) begin
          seq_state_d = SEQ_RUN;
          hold_cnt_d = hold_time_q;
        end else if (fault_blocks || (sto_on && !seq_cfg_q)) begin
          seq_state_d = SEQ_OPEN;
        end else if (hold_done) begin
          seq_state_d = SEQ_OPEN;
        end else begin
          hold_cnt_d = hold_cnt_q - 32'h0000_0001;
        end
      end
      default: begin
        seq_state_d = SEQ_OPEN;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      seq_state_q <= SEQ_OPEN;
      hold_cnt_q <= 32'h0000_0000;
    end else begin
      seq_state_q <= seq_state_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // ==========================================================
  // Feedback monitor and fault latch
  wire fb_mismatch = fb_enabled && (fb_ok != cmd_d);
  wire fb_timeout = fb_mismatch && (cmd_d == cmd_prev_q) && (mon_cnt_q >= mon_time_q);
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cmd_prev_q <= 1'b0;
      mon_cnt_q <= 32'h0000_0000;
      fault_q <= 1'b0;
    end else begin
      cmd_prev_q <= cmd_d;
      if (cmd_d != cmd_prev_q) begin
        mon_cnt_q <= 32'h0000_0000;
      end else if (fb_mismatch) begin
        if (mon_cnt_q != 32'hFFFF_FFFF) begin
          mon_cnt_q <= mon_cnt_q + 32'h0000_0001;
        end
      end else begin
        mon_cnt_q <= 32'h0000_0000;
      end
      // A timeout in the same cycle as an acknowledge wins, so no fault is ever lost.
      if (fb_timeout) begin
        fault_q <= 1'b1;
      end else if (ack_on) begin
        fault_q <= 1'b0;
      end
    end
  end
  wire fault_rise = ~fault_q & fb_timeout;
  wire open_evt = cmd_prev_q & ~cmd_d;
  reg [1:0] irq_set;
  always @* begin
    irq_set = 2'h0;
    irq_set[`LCS_IRQ_FAULT] = fault_rise;
    irq_set[`LCS_IRQ_OPEN] = open_evt;
  end
  wire [1:0] irq_clr = wr_irq ? pwdata_i[1:0] : 2'h0;

  // ==========================================================
  // Register writes and interrupt status
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      fb_src_q <= `LCS_SRC_NONE;
      fb_di_q <= 3'h0;
      seq_cfg_q <= 1'b0;
      force_q <= 1'b0;
      mon_time_q <= MON_CYC_DEF;
      hold_time_q <= HOLD_CYC_DEF;
      out_sel_q <= 8'h00;
      irq_mask_q <= 2'h0;
      irq_stat_q <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        fb_src_q <= pwdata_i[`LCS_CTRL_SRC_MSB:`LCS_CTRL_SRC_LSB];
        fb_di_q <= pwdata_i[`LCS_CTRL_DI_MSB:`LCS_CTRL_DI_LSB];
        seq_cfg_q <= pwdata_i[`LCS_CTRL_SEQ];
        force_q <= pwdata_i[`LCS_CTRL_FORCE];
      end
      if (wr_mon) begin
        mon_time_q <= pwdata_i;
      end
      if (wr_hold) begin
        hold_time_q <= pwdata_i;
      end
      if (wr_osel) begin
        out_sel_q <= pwdata_i[7:0];
      end
      if (wr_mask) begin
        irq_mask_q <= pwdata_i[1:0];
      end
      // Set wins over a write-one clear in the same cycle.
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ==========================================================
  // Digital outputs and read data
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      digital_output_o <= 8'h00;
    end else begin
      digital_output_o <= out_sel_q & {8{cmd_d}};
    end
  end

  // Read words are built from the field positions so the map lives in one place.
  reg [31:0] ctrl_word;
  reg [31:0] status_word;
  always @* begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`LCS_CTRL_SRC_MSB:`LCS_CTRL_SRC_LSB] = fb_src_q;
    ctrl_word[`LCS_CTRL_DI_MSB:`LCS_CTRL_DI_LSB] = fb_di_q;
    ctrl_word[`LCS_CTRL_SEQ] = seq_cfg_q;
    ctrl_word[`LCS_CTRL_FORCE] = force_q;
  end
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`LCS_ST_ACT] = cmd_d;
    status_word[`LCS_ST_FB] = fb_ok;
    status_word[`LCS_ST_FAULT] = fault_q;
    status_word[`LCS_ST_HOLD] = hold_on;
  end

  always @* begin
    prdata_o = 32'h0000_0000;
    if (rd_en) begin
      case (paddr_i)
        `LCS_ADDR_CTRL: prdata_o = ctrl_word;
        `LCS_ADDR_MON_TIME: prdata_o = mon_time_q;
        `LCS_ADDR_HOLD_TIME: prdata_o = hold_time_q;
        `LCS_ADDR_OUT_SEL: prdata_o = {24'h0, out_sel_q};
        `LCS_ADDR_STATUS: prdata_o = status_word;
        `LCS_ADDR_IRQ_STAT: prdata_o = {30'h0, irq_stat_q};
        `LCS_ADDR_IRQ_MASK: prdata_o = {30'h0, irq_mask_q};
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end
endmodule // lcs_line_contactor_sequencer
